/* File: rtl/synth_load.sv */
// dual-section synthesizer serial load, dividers, phase detector and switches
`timescale 1ns/1ps
module synth_load (
  input  wire logic clock,           // reference oscillator, 250 MHz
  input  wire logic rst_b,
  input  wire logic serialClk,       // link clock from the host
  input  wire logic serialData,      // link data, sampled on serialClk
  input  wire logic loadStrobe,      // load strobe pin
  input  wire logic rxSupply,        // high while the reception supply is up
  input  wire logic txPrescalerIn,   // transmit prescaler input pin
  input  wire logic rxPrescalerIn,   // reception prescaler input pin
  output logic      refCompareFreq,  // reference pulse
  output logic      dividerMonitorOut,
  output logic      txPumpOut,
  output logic      txPumpOe_b,
  output logic      rxPumpOut,
  output logic      rxPumpOe_b,
  output logic      txSwitchedOut,
  output logic      txSwitchedOe_b,
  output logic      rxSwitchedOut,
  output logic      rxSwitchedOe_b
);

  // link side word
  logic [synth_pkg::WORD_W-1:0] shiftWord;   // quasi-static while strobe is high

  // pin synchronisers, stage one is read only by stage two
  logic strobeMeta_q;
  logic strobeSync_q;
  logic strobeHeld_q;  // strobe already high one cycle earlier
  logic supplyMeta_q;
  logic supplySync_q;
  logic txInMeta_q;
  logic txInSync_q;
  logic txInLast_q;
  logic rxInMeta_q;
  logic rxInSync_q;
  logic rxInLast_q;

  // captured word and its fields
  logic [synth_pkg::WORD_W-1:0]    word_q;   // sampled while strobe high
  logic                            latchSel;
  logic                            refSelBit;
  logic                            monSelBit;
  logic                            polBit;
  logic [synth_pkg::SWALLOW_W-1:0] swallowField;
  logic [synth_pkg::MAIN_W-1:0]    mainField;
  logic                            loadTx;   // copy into transmit latch
  logic                            loadRx;   // copy into reception latch

  // section latches
  logic [synth_pkg::MAIN_W-1:0]    txMain_q;
  logic [synth_pkg::SWALLOW_W-1:0] txSwallow_q;
  logic                            txPol_q;
  logic [synth_pkg::MAIN_W-1:0]    rxMain_q;
  logic [synth_pkg::SWALLOW_W-1:0] rxSwallow_q;
  logic                            rxPol_q;
  logic                            refSel_q;  // high selects 512
  logic                            monSel_q;  // high shows transmit

  // reference counter
  logic [synth_pkg::REF_W-1:0] refCnt_q;
  logic [synth_pkg::REF_W-1:0] refLimit;
  logic                        refPulse_q;

  // dividers and detectors
  logic                txEdge;
  logic                rxEdge;
  logic                txDiv;
  logic                rxDiv;
  synth_pkg::pump_e    txState_q;
  synth_pkg::pump_e    rxState_q;

  // registered outputs
  logic monitor_q;
  logic txPump_q;
  logic txPumpOe_b_q;
  logic rxPump_q;
  logic rxPumpOe_b_q;
  logic txSw_q;
  logic txSwOe_b_q;
  logic rxSw_q;
  logic rxSwOe_b_q;

  // next detector state from the two pulses of one compare period
  function automatic synth_pkg::pump_e nextPump(
    input synth_pkg::pump_e state,
    input logic             refP,
    input logic             divP);
    synth_pkg::pump_e nxt;
    nxt = state;
    if (refP && !divP) begin
      // reference ahead: lift, or settle if the divider was ahead
      nxt = (state == synth_pkg::PUMP_DOWN) ? synth_pkg::PUMP_OFF : synth_pkg::PUMP_UP;
    end else if (divP && !refP) begin
      nxt = (state == synth_pkg::PUMP_UP) ? synth_pkg::PUMP_OFF : synth_pkg::PUMP_DOWN;
    end else if (refP && divP) begin
      nxt = synth_pkg::PUMP_OFF;  // coincident edges: no error
    end
    return nxt;
  endfunction : nextPump

  // drive level of a pump in a non-idle state
  function automatic logic pumpLevel(
    input synth_pkg::pump_e state,
    input logic             pol);
    return (state == synth_pkg::PUMP_UP) ? pol : !pol;
  endfunction : pumpLevel

  // serial word assembly on the link clock
  serial_shifter shifter (
    .serialClk (serialClk),
    .rst_b     (rst_b),
    .serialData(serialData),
    .shiftWord (shiftWord)
  );

  // strobe and supply pins cross into the oscillator domain
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      strobeMeta_q <= 1'b0;
      strobeSync_q <= 1'b0;
      strobeHeld_q <= 1'b0;
      supplyMeta_q <= 1'b0;
      supplySync_q <= 1'b0;
    end else begin
      strobeMeta_q <= loadStrobe;
      strobeSync_q <= strobeMeta_q;
      strobeHeld_q <= strobeSync_q;
      supplyMeta_q <= rxSupply;
      supplySync_q <= supplyMeta_q;
    end
  end

  // prescaler inputs, with a third stage for rising edge detection
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      txInMeta_q <= 1'b0;
      txInSync_q <= 1'b0;
      txInLast_q <= 1'b0;
      rxInMeta_q <= 1'b0;
      rxInSync_q <= 1'b0;
      rxInLast_q <= 1'b0;
    end else begin
      txInMeta_q <= txPrescalerIn;
      txInSync_q <= txInMeta_q;
      txInLast_q <= txInSync_q;
      rxInMeta_q <= rxPrescalerIn;
      rxInSync_q <= rxInMeta_q;
      rxInLast_q <= rxInSync_q;
    end
  end

  assign txEdge = txInSync_q && !txInLast_q;
  assign rxEdge = rxInSync_q && !rxInLast_q;

  // the word is sampled only behind the synchronised strobe; the host
  // holds the serial clock still then, so every bit is settled
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      word_q <= '0;
    end else if (strobeSync_q) begin
      word_q <= shiftWord;
    end
  end

  // field split of the captured word
  assign latchSel     = word_q[synth_pkg::LATCH_SEL_POS];
  assign refSelBit    = word_q[synth_pkg::REF_SEL_POS];
  assign monSelBit    = word_q[synth_pkg::MON_SEL_POS];
  assign polBit       = word_q[synth_pkg::POL_SEL_POS];
  assign swallowField =
    word_q[synth_pkg::SWALLOW_LSB +: synth_pkg::SWALLOW_W];
  assign mainField    = word_q[synth_pkg::MAIN_LSB +: synth_pkg::MAIN_W];
  // word_q lags the strobe by one cycle, so both must hold
  assign loadTx = strobeSync_q && strobeHeld_q && latchSel;
  assign loadRx = strobeSync_q && strobeHeld_q && !latchSel;

  // transmit latch, untouched by reception loads
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      txMain_q    <= synth_pkg::MAIN_RST;
      txSwallow_q <= synth_pkg::SWALLOW_RST;
      txPol_q     <= 1'b0;
    end else if (loadTx) begin
      txMain_q    <= mainField;
      txSwallow_q <= swallowField;
      txPol_q     <= polBit;
    end
  end

  // reception latch; losing its supply wipes it before any load
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rxMain_q    <= synth_pkg::MAIN_RST;
      rxSwallow_q <= synth_pkg::SWALLOW_RST;
      rxPol_q     <= 1'b0;
    end else if (!supplySync_q) begin
      rxMain_q    <= synth_pkg::MAIN_RST;
      rxSwallow_q <= synth_pkg::SWALLOW_RST;
      rxPol_q     <= 1'b0;
    end else if (loadRx) begin
      rxMain_q    <= mainField;
      rxSwallow_q <= swallowField;
      rxPol_q     <= polBit;
    end
  end

  // shared settings follow the most recent load of either section; supply loss clears the reference choice
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      refSel_q <= 1'b0;
      monSel_q <= 1'b0;
    end else begin
      if (!supplySync_q) begin
        refSel_q <= 1'b0;
      end else if (loadTx || loadRx) begin
        refSel_q <= refSelBit;
      end
      if (loadTx || loadRx) begin
        monSel_q <= monSelBit;
      end
    end
  end

  // reference counter: one compare pulse per 512 or 1024 oscillator cycles
  assign refLimit = refSel_q ? synth_pkg::REF_DIV_HI : synth_pkg::REF_DIV_LO;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      refCnt_q   <= '0;
      refPulse_q <= 1'b0;
    end else begin
      // a shortened limit must not strand the count above it
      if (refCnt_q >= refLimit - 1'b1) begin
        refCnt_q   <= '0;
        refPulse_q <= 1'b1;
      end else begin
        refCnt_q   <= refCnt_q + 1'b1;
        refPulse_q <= 1'b0;
      end
    end
  end

  // programmable dividers, one per section
  pulse_divider txDivider (
    .clock       (clock),
    .rst_b       (rst_b),
    .inEdge      (txEdge),
    .mainRatio   (txMain_q),
    .swallowRatio(txSwallow_q),
    .divPulse    (txDiv)
  );

  pulse_divider rxDivider (
    .clock       (clock),
    .rst_b       (rst_b),
    .inEdge      (rxEdge),
    .mainRatio   (rxMain_q),
    .swallowRatio(rxSwallow_q),
    .divPulse    (rxDiv)
  );

  // phase detector state per section
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      txState_q <= synth_pkg::PUMP_OFF;
      rxState_q <= synth_pkg::PUMP_OFF;
    end else begin
      txState_q <= nextPump(txState_q, refPulse_q, txDiv);
      rxState_q <= nextPump(rxState_q, refPulse_q, rxDiv);
    end
  end

  // pump pins: enable low while driving, released when phases agree
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      txPump_q     <= 1'b0;
      txPumpOe_b_q <= 1'b1;
      rxPump_q     <= 1'b0;
      rxPumpOe_b_q <= 1'b1;
    end else begin
      case (txState_q)
        synth_pkg::PUMP_UP, synth_pkg::PUMP_DOWN: begin
          txPump_q     <= pumpLevel(txState_q, txPol_q);
          txPumpOe_b_q <= 1'b0;
        end
        default: begin
          txPump_q     <= 1'b0;
          txPumpOe_b_q <= 1'b1;
        end
      endcase
      case (rxState_q)
        synth_pkg::PUMP_UP, synth_pkg::PUMP_DOWN: begin
          rxPump_q     <= pumpLevel(rxState_q, rxPol_q);
          rxPumpOe_b_q <= 1'b0;
        end
        default: begin
          rxPump_q     <= 1'b0;
          rxPumpOe_b_q <= 1'b1;
        end
      endcase
    end
  end

  // switches pass the pump only during a load of their own section
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      txSw_q     <= 1'b0;
      txSwOe_b_q <= 1'b1;
      rxSw_q     <= 1'b0;
      rxSwOe_b_q <= 1'b1;
    end else begin
      txSw_q     <= loadTx && txPump_q;
      txSwOe_b_q <= !(loadTx && !txPumpOe_b_q);
      rxSw_q     <= loadRx && rxPump_q;
      rxSwOe_b_q <= !(loadRx && !rxPumpOe_b_q);
    end
  end

  // divider monitor selection
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      monitor_q <= 1'b0;
    end else begin
      monitor_q <= monSel_q ? txDiv : rxDiv;
    end
  end

  assign refCompareFreq    = refPulse_q;
  assign dividerMonitorOut = monitor_q;
  assign txPumpOut         = txPump_q;
  assign txPumpOe_b        = txPumpOe_b_q;
  assign rxPumpOut         = rxPump_q;
  assign rxPumpOe_b        = rxPumpOe_b_q;
  assign txSwitchedOut     = txSw_q;
  assign txSwitchedOe_b    = txSwOe_b_q;
  assign rxSwitchedOut     = rxSw_q;
  assign rxSwitchedOe_b    = rxSwOe_b_q;

  tx_load_a: assert property (
    @(posedge clock) disable iff (!rst_b)
    loadTx |=> txMain_q == $past(mainField) && txSwallow_q == $past(swallowField))
    else $error("transmit latch missed a load");

  tx_hold_a: assert property (
    @(posedge clock) disable iff (!rst_b)
    !loadTx |=> $stable(txMain_q) && $stable(txSwallow_q) && $stable(txPol_q))
    else $error("transmit latch changed without its load");

  rx_supply_a: assert property (
    @(posedge clock) disable iff (!rst_b)
    !supplySync_q |=> rxMain_q == synth_pkg::MAIN_RST && !refSel_q)
    else $error("reception settings kept after supply loss");

  ref_wrap_a: assert property (
    @(posedge clock) disable iff (!rst_b)
    refPulse_q |-> $past(refCnt_q) == refLimit - 1'b1 || $past(refSel_q) != refSel_q
                   || $past(refCnt_q) >= $past(refLimit))
    else $error("reference pulse at wrong count");

  ref_count_a: assert property (
    @(posedge clock) disable iff (!rst_b)
    $stable(refSel_q) && refCnt_q != '0 |-> !refPulse_q ##1 refCnt_q == '0 || !refPulse_q)
    else $error("reference pulse off its count");

  monitor_sel_a: assert property (
    @(posedge clock) disable iff (!rst_b)
    1'b1 |=> monitor_q == ($past(monSel_q) ? $past(txDiv) : $past(rxDiv)))
    else $error("monitor shows the wrong section");

  pump_sense_a: assert property (
    @(posedge clock) disable iff (!rst_b)
    $past(txState_q) == synth_pkg::PUMP_UP |-> !txPumpOe_b && txPumpOut == $past(txPol_q))
    else $error("pump drive sense wrong");

  tx_switch_a: assert property (
    @(posedge clock) disable iff (!rst_b)
    !txSwitchedOe_b |-> $past(strobeSync_q) && $past(latchSel) && $past(txPump_q) == txSwitchedOut)
    else $error("transmit switch on outside its load");

  rx_switch_a: assert property (
    @(posedge clock) disable iff (!rst_b)
    loadRx && !rxPumpOe_b_q |=> !rxSwitchedOe_b && rxSwitchedOut == $past(rxPump_q))
    else $error("reception switch failed to pass the pump");

endmodule : synth_load

/* File: shared/synth_pkg.sv */
// constants, types and helpers shared by the synthesizer load logic
package synth_pkg;

  // serial control word, bit i holds word position i+1
  localparam int WORD_W         = 23;
  localparam int LATCH_SEL_POS  = 0;   // position 1
  localparam int REF_SEL_POS    = 1;   // position 2
  localparam int MON_SEL_POS    = 2;   // position 3
  localparam int FILLER_POS     = 3;   // position 4, host sends low
  localparam int POL_SEL_POS    = 4;   // position 5
  localparam int SWALLOW_LSB    = 5;   // positions 6..12
  localparam int SWALLOW_W      = 7;
  localparam int MAIN_LSB       = 12;  // positions 13..23
  localparam int MAIN_W         = 11;

  // divider figures
  localparam int PRESCALE_BASE  = 64;  // dual-modulus base ratio
  localparam int PRESCALE_SHIFT = 6;   // log2 of the base ratio
  localparam int MAIN_MIN       = 16;  // least legal main ratio
  localparam int TOTAL_W        = 18;  // holds 64*2047+127
  localparam int REF_W          = 11;
  localparam logic [REF_W-1:0] REF_DIV_HI = 11'h200;  // 512
  localparam logic [REF_W-1:0] REF_DIV_LO = 11'h400;  // 1024

  // reset values of the section latches
  localparam logic [MAIN_W-1:0]    MAIN_RST    = 11'h000;
  localparam logic [SWALLOW_W-1:0] SWALLOW_RST = 7'h00;

  // phase detector state of one section
  typedef enum logic [1:0] {PUMP_OFF, PUMP_UP, PUMP_DOWN} pump_e;

  // overall division of the prescaler and counter pair
  function automatic logic [TOTAL_W-1:0] totalRatio(
    input logic [MAIN_W-1:0]    mainRatio,
    input logic [SWALLOW_W-1:0] swallowRatio);
    return TOTAL_W'({mainRatio, 6'h00}) + TOTAL_W'(swallowRatio);
  endfunction : totalRatio

endpackage : synth_pkg

/* File: rtl/serial_shifter.sv */
// serial-clock side shift register that gathers the control word
`timescale 1ns/1ps
module serial_shifter (
  input  wire logic                           serialClk,
  input  wire logic                           rst_b,
  input  wire logic                           serialData,
  output logic [synth_pkg::WORD_W-1:0]        shiftWord
);

  logic [synth_pkg::WORD_W-1:0] shift_q;  // word under assembly

  // new bit enters at position 1 and walks toward position 23, so the
  // first bit sent (main count MSB) ends at position 23, the select at 1
  always_ff @(posedge serialClk or negedge rst_b) begin
    if (!rst_b) begin
      shift_q <= '0;
    end else begin
      shift_q <= {shift_q[synth_pkg::WORD_W-2:0], serialData};
    end
  end

  assign shiftWord = shift_q;

  shift_entry_a: assert property (
    @(posedge serialClk) disable iff (!rst_b)
    1'b1 |=> shift_q[0] == $past(serialData)
         && shift_q[synth_pkg::WORD_W-1:1] == $past(shift_q[synth_pkg::WORD_W-2:0]))
    else $error("shift register did not take the data bit");

endmodule : serial_shifter

/* File: rtl/pulse_divider.sv */
// pulse-swallow programmable divider: one output pulse per 64*N+A input edges
`timescale 1ns/1ps
module pulse_divider (
  input  wire logic                              clock,
  input  wire logic                              rst_b,
  input  wire logic                              inEdge,
  input  wire logic [synth_pkg::MAIN_W-1:0]      mainRatio,
  input  wire logic [synth_pkg::SWALLOW_W-1:0]   swallowRatio,
  output logic                                   divPulse
);

  logic [synth_pkg::TOTAL_W-1:0] total;     // ratio now programmed
  logic [synth_pkg::TOTAL_W-1:0] count_q;   // edges left in this period
  logic                          pulse_q;   // registered output pulse

  assign total = synth_pkg::totalRatio(mainRatio, swallowRatio);

  // count edges down; a new ratio only takes effect at the next reload
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      count_q <= '0;
      pulse_q <= 1'b0;
    end else begin
      pulse_q <= 1'b0;
      if (inEdge) begin
        if (count_q == '0) begin
          // a zero ratio is unprogrammed, so stay silent
          count_q <= (total == '0) ? '0 : total - 1'b1;
          pulse_q <= (total != '0);
        end else begin
          count_q <= count_q - 1'b1;
        end
      end
    end
  end

  assign divPulse = pulse_q;

  div_pulse_cause_a: assert property (
    @(posedge clock) disable iff (!rst_b)
    pulse_q |-> $past(inEdge) && $past(count_q) == '0 && $past(total) != '0)
    else $error("divider pulse without terminal count");

endmodule : pulse_divider

/* File: tb/serial_host.sv */
// host model that shifts control words over the link and drives the load strobe
`timescale 1ns/1ps
module serial_host (
  input  wire logic clock,
  output logic      serialClk,
  output logic      serialData,
  output logic      loadStrobe
);
  // link idles with its clock still and the strobe low
  initial begin
    serialClk  = 1'b0;
    serialData = 1'b1;
    loadStrobe = 1'b0;
  end

  // one frame of 23 bits at a 64 ns link period; data moves only while the link clock is low
  task automatic shiftWord(input logic [synth_pkg::WORD_W-1:0] w);
    #5; // keeps link edges off the oscillator edges
    for (int i = synth_pkg::WORD_W - 1; i >= 0; i--) begin
      serialData = w[i]; // filler arrives low from the word builder
      #32 serialClk = 1'b1;
      #32 serialClk = 1'b0;
    end
    serialData = ~w[0]; // released line must not keep showing the last bit
  endtask : shiftWord

  // strobe moves on the oscillator edge; only raised with the link clock still
  task automatic setStrobe(input logic level);
    @(posedge clock);
    loadStrobe <= level;
  endtask : setStrobe
endmodule : serial_host

/* File: tb/synth_load_tb.sv */
// self-checking bench for the dual synthesizer serial load logic
`timescale 1ns/1ps
module synth_load_tb;
  logic       clock, rst_b, rxSupply, runPre;  // oscillator, reset, supply, prescaler run
  logic [1:0] preCnt_q;                        // prescaler waveform divider
  logic       serialClk, serialData, loadStrobe;
  logic       refCompareFreq, dividerMonitorOut, txPumpOut, txPumpOe_b, rxPumpOut, rxPumpOe_b;
  logic       txSwitchedOut, txSwitchedOe_b, rxSwitchedOut, rxSwitchedOe_b;
  int         error_cnt, checks_done, cycles, n;

  synth_load i_dut (
    .clock(clock), .rst_b(rst_b), .serialClk(serialClk), .serialData(serialData),
    .loadStrobe(loadStrobe), .rxSupply(rxSupply),
    .txPrescalerIn(preCnt_q[1]), .rxPrescalerIn(preCnt_q[1]),
    .refCompareFreq(refCompareFreq), .dividerMonitorOut(dividerMonitorOut),
    .txPumpOut(txPumpOut), .txPumpOe_b(txPumpOe_b),
    .rxPumpOut(rxPumpOut), .rxPumpOe_b(rxPumpOe_b),
    .txSwitchedOut(txSwitchedOut), .txSwitchedOe_b(txSwitchedOe_b),
    .rxSwitchedOut(rxSwitchedOut), .rxSwitchedOe_b(rxSwitchedOe_b)
  );

  serial_host i_host (
    .clock(clock), .serialClk(serialClk), .serialData(serialData), .loadStrobe(loadStrobe)
  );

  // 250 MHz oscillator
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  // prescaler inputs: each phase two cycles, the shortest the synchroniser accepts
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      preCnt_q <= 2'h0;
    end else if (runPre) begin
      preCnt_q <= preCnt_q + 2'h1;
    end
  end

  // hang guard: about twice the expected run
  always @(posedge clock) begin
    cycles++;
    if (cycles == 90000) begin
      error_cnt++;
      test_done();
    end
  end

  task automatic test_done();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : test_done

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %0d seen %0d", what, exp, seen);
    end
  endtask : check

  // control word, bit i is word position i+1; filler forced low, main kept >= 16
  function automatic logic [synth_pkg::WORD_W-1:0] word(input logic tx, refSel, mon, pol,
    input logic [synth_pkg::MAIN_W-1:0] mainN, input logic [synth_pkg::SWALLOW_W-1:0] swal);
    return {mainN, swal, pol, 1'b0, mon, refSel, tx};
  endfunction : word

  function automatic logic pick(input bit mon);
    return mon ? dividerMonitorOut : refCompareFreq;
  endfunction : pick

  // cycles from here to the next pulse, sampled on the falling edge where outputs settle
  task automatic waitPulse(input bit mon, input int limit, output int gap);
    gap = 0;
    do begin
      @(negedge clock);
      gap++;
    end while (pick(mon) !== 1'b1 && gap < limit);
  endtask : waitPulse

  // first interval after a change may be partial, so two pulses are skipped
  task automatic period(input bit mon, input int exp, input string what);
    waitPulse(mon, 2 * exp + 200, n);
    waitPulse(mon, 2 * exp + 200, n);
    waitPulse(mon, 2 * exp + 200, n);
    check(what, n, exp);
  endtask : period

  // full load: frame, strobe held nine cycles, then a quiet gap
  task automatic load(input logic [synth_pkg::WORD_W-1:0] w);
    i_host.shiftWord(w);
    i_host.setStrobe(1'b1);
    repeat (8) @(posedge clock);
    i_host.setStrobe(1'b0);
    repeat (8) @(posedge clock);
  endtask : load

  // frame, strobe raised and held past the load and a reference pulse
  task automatic strobeAcross(input logic [synth_pkg::WORD_W-1:0] w);
    i_host.shiftWord(w);
    i_host.setStrobe(1'b1);
    repeat (6) @(posedge clock);
    waitPulse(1'b0, 1100, n);
    repeat (3) @(negedge clock);
  endtask : strobeAcross

  // main sequence
  initial begin
    rst_b       = 1'b0;
    rxSupply    = 1'b1;
    runPre      = 1'b0;
    error_cnt   = 0;
    checks_done = 0;
    cycles      = 0;
    repeat (2) @(posedge clock);
    rst_b <= 1'b1;
    repeat (4) @(posedge clock);
    period(1'b0, 1024, "reference period at reset");
    repeat (3) @(negedge clock);
    check("tx pump enable", txPumpOe_b, 1'b0);
    check("tx pump level", txPumpOut, 1'b0);
    check("rx pump enable", rxPumpOe_b, 1'b0);
    check("rx pump level", rxPumpOut, 1'b0);
    // rx load with prescalers still, strobe held across a reference pulse
    strobeAcross(word(1'b0, 1'b0, 1'b0, 1'b1, 11'h010, 7'h00));
    check("rx pump level raised", rxPumpOut, 1'b1);
    check("rx switched enable", rxSwitchedOe_b, 1'b0);
    check("rx switched level", rxSwitchedOut, 1'b1);
    check("tx switched enable idle", txSwitchedOe_b, 1'b1);
    i_host.setStrobe(1'b0);
    repeat (8) @(negedge clock);
    check("rx switched enable off", rxSwitchedOe_b, 1'b1);
    // tx load with strobe held across a reference pulse
    strobeAcross(word(1'b1, 1'b1, 1'b1, 1'b1, 11'h010, 7'h03));
    check("tx switched enable", txSwitchedOe_b, 1'b0);
    check("tx switched level", txSwitchedOut, 1'b1);
    check("rx switched enable", rxSwitchedOe_b, 1'b1);
    i_host.setStrobe(1'b0);
    repeat (8) @(negedge clock);
    check("tx switched enable off", txSwitchedOe_b, 1'b1);
    period(1'b0, 512, "reference period");
    @(posedge clock);
    runPre <= 1'b1;
    period(1'b1, 1027 * 4, "tx monitor period");
    load(word(1'b0, 1'b1, 1'b1, 1'b0, 11'h011, 7'h00));
    period(1'b1, 1027 * 4, "tx monitor after rx load");
    load(word(1'b0, 1'b1, 1'b0, 1'b0, 11'h011, 7'h00));
    period(1'b1, 1088 * 4, "rx monitor period");
    // supply loss drops the rx ratio and the reference choice
    @(posedge clock);
    rxSupply <= 1'b0;
    period(1'b0, 1024, "reference after supply loss");
    n = 0;
    repeat (5000) begin
      @(negedge clock);
      n += (dividerMonitorOut === 1'b1);
    end
    check("rx pulses after supply loss", n, 0);
    test_done();
  end
endmodule : synth_load_tb
